//--- hdl/memory_space_decoder.v
// Address decoder and router for the 16-Mbyte linear memory space.
// Behaviour
// - Linear 16 MB: 256 segments, 1024 pages
// - Code, data, registers share one space
// - Byte and word accesses everywhere
// - Data and dual-port RAMs and register areas in segment 0
// - Two 512-byte word register areas
// - Dual-port RAM holds 16-register banks
// - Top 256 dual-port RAM bytes bit-addressable
// - Active register bank locations bit-addressable
// - Program memories via code unit, others via data unit
// - System bus carries both directions concurrently
// - Programmable-size program SRAM write protection
// - Serial and CAN windows via bus unit
// - External I/O disables pipeline optimisations
// - About 12 MB of external memory windows
// - Up to three 256 KB flash modules, 4 KB sectors
// - Top sector of flash segment 0 reserved
// - Sector erase, 128-byte program blocks
// - Write protection per sector cluster
// - Flash read protection, password unlock
// - 128-bit flash reads, always corrected
// - Flash modules accessed in parallel
`timescale 1ns/100ps
`default_nettype none
`include "memory_space_decoder_defs.vh"

module memory_space_decoder (
  input wire sys_clk,
  input wire reset,
  // Code fetch side.
  input wire fetch_valid,
  input wire [23:0] fetch_addr,
  output wire fetch_ready,
  output reg fetch_done,
  output reg [11:0] fetch_target,
  output reg [23:0] fetch_phys_addr,
  output reg fetch_trap,
  // Data transfer side.
  input wire data_valid,
  input wire data_write,
  input wire data_word,
  input wire [23:0] data_addr,
  output wire data_ready,
  output reg data_done,
  output reg [11:0] data_target,
  output reg [23:0] data_phys_addr,
  output reg data_byte_hi,
  output reg data_trap,
  output reg data_write_blocked,
  output reg data_bit_ok,
  output reg data_strict_order,
  output reg code_unit_sel,
  output reg [7:0] data_segment,
  output reg [1:0] data_page,
  // Flash routing.
  output reg [2:0] flash_module_sel,
  output reg [5:0] flash_sector,
  output reg [2:0] flash_cluster,
  output reg [10:0] flash_block,
  output reg [13:0] flash_line,
  // Configuration.
  input wire [15:0] program_sram_protect_size,
  input wire [7:0] flash_wp_clusters,
  input wire flash_read_protect,
  input wire flash_unlocked,
  input wire [10:0] context_base
);

  // ****************************************************************
  // Decode function
  // ****************************************************************
  // Returns {trap, target, physical address} for an address.
  function [36:0] decode;
    input [23:0] a;
    reg [11:0] t;
    reg [23:0] p;
    reg tr;
    begin
      t = `TGT_NONE;
      p = a;
      tr = 1'b0;
      if (a >= `FLASH_INT_BASE) begin
        t = `TGT_FLASH_IF;
      end else if (a >= `TRAP_HI_BASE) begin
        tr = 1'b1;
      end else if (a >= `EMULATED_PROGRAM_SRAM_MIRROR_BASE) begin
        t = `TGT_EMULATED_PROGRAM_SRAM;
        p = {a[23:16] & 8'h00 | 8'he8, a[15:0]};
      end else if (a >= `EMULATED_PROGRAM_SRAM_BASE) begin
        t = `TGT_EMULATED_PROGRAM_SRAM;
      end else if (a >= `PROGRAM_SRAM_MIRROR_BASE) begin
        t = `TGT_PROGRAM_SRAM;
        p = {8'he0, a[15:0]};
      end else if (a >= `PROGRAM_SRAM_BASE) begin
        t = `TGT_PROGRAM_SRAM;
      end else if (a >= `PROG_RSV_BASE) begin
        tr = 1'b1;
      end else if (a >= `FLASH0_BASE) begin
        if (a[23:12] == 12'hc0f) begin
          tr = 1'b1;
        end else begin
          t = `TGT_FLASH;
        end
      end else if (a >= `EXT_MEM_HI_BASE) begin
        t = `TGT_EXT;
      end else if (a >= `EXT_IO_BASE) begin
        t = `TGT_EXT_IO;
      end else if (a >= `CAN_REG_BASE) begin
        t = `TGT_BUS_UNIT;
      end else if (a >= `EXT_MEM_MID_BASE) begin
        t = `TGT_EXT;
      end else if (a >= `PRIMARY_REG_BASE) begin
        t = `TGT_PRIMARY;
      end else if (a >= `DUAL_PORT_RAM_BASE) begin
        t = `TGT_DUAL_PORT_RAM;
      end else if (a >= `DUAL_PORT_RAM_RSV_BASE) begin
        tr = 1'b1;
      end else if (a >= `EXTENDED_REG_BASE) begin
        t = `TGT_EXTENDED;
      end else if (a >= `EXTRA_REG_BASE) begin
        t = `TGT_EXTRA;
      end else if (a >= `DATA_SRAM_BASE) begin
        t = `TGT_DATA_SRAM;
      end else if (a >= `DATA_SRAM_RSV_BASE) begin
        tr = 1'b1;
      end else begin
        t = `TGT_EXT;
      end
      decode = {tr, t, p};
    end
  endfunction

  // ****************************************************************
  // Flash module busy tracking
  // ****************************************************************
  // Each module has its own one-cycle busy flag, so accesses to
  // different modules never wait on each other.
  wire [36:0] fetch_dec;
  wire [36:0] data_dec;
  wire [2:0] fetch_mod;
  wire [2:0] data_mod;
  wire flash_clash;
  wire [2:0] module_busy_next;

  assign fetch_dec = decode(fetch_addr);
  assign data_dec = decode(data_addr);

  // ****************************************************************
  // Decode word slices
  // ****************************************************************
  // The decode word is {trap, one-hot target, physical address}.
  wire fetch_trap_now;
  wire [11:0] fetch_tgt_now;
  wire [23:0] fetch_phys_now;
  wire fetch_is_flash;
  wire data_trap_now;
  wire [11:0] data_tgt_now;
  wire [23:0] data_phys_now;
  wire data_is_flash;
  wire data_is_dual_port_ram;
  wire data_taken;

  assign fetch_trap_now = fetch_dec[36];
  assign fetch_tgt_now = fetch_dec[35:24];
  assign fetch_phys_now = fetch_dec[23:0];
  assign fetch_is_flash = fetch_dec[27];
  assign data_trap_now = data_dec[36];
  assign data_tgt_now = data_dec[35:24];
  assign data_phys_now = data_dec[23:0];
  assign data_is_flash = data_dec[27];
  assign data_is_dual_port_ram = data_dec[34];

  genvar m;
  generate
    for (m = 0; m < 3; m = m + 1) begin : g_mod
      assign fetch_mod[m] = fetch_valid & fetch_is_flash &
        (fetch_addr[19:18] == m);
      assign data_mod[m] = data_valid & data_is_flash &
        (data_addr[19:18] == m);
      assign module_busy_next[m] = fetch_mod[m] | data_mod[m];
    end
  endgenerate

  // Both units may hit the same module; the code side wins that cycle.
  assign flash_clash = |(fetch_mod & data_mod);
  assign fetch_ready = 1'b1;
  assign data_ready = ~flash_clash;
  // A refused data request leaves the held data results untouched, but the flash sector, cluster, block and line fields still load its address.
  assign data_taken = data_valid & ~flash_clash;

  // ****************************************************************
  // Data-side checks
  // ****************************************************************
  wire [2:0] data_cluster;
  wire program_sram_hit;
  wire program_sram_protected;
  wire flash_wp_hit;
  wire flash_rd_block;
  wire [23:0] dp_diff;
  wire [10:0] dp_off;
  wire reg_area_hit;
  wire prog_mem_hit;
  wire in_bank;
  wire bit_region;

  assign data_cluster = data_addr[17:15];
  assign program_sram_hit = data_dec[28];
  assign program_sram_protected = program_sram_hit &
    (data_dec[15:0] < program_sram_protect_size);
  assign flash_wp_hit = data_dec[27] &
    flash_wp_clusters[data_cluster];
  assign flash_rd_block = data_dec[27] & flash_read_protect &
    ~flash_unlocked;
  // The offset is taken modulo the RAM size; the target gate below
  // keeps addresses outside the dual-port RAM from matching a bank.
  assign dp_diff = data_addr - `DUAL_PORT_RAM_BASE;
  assign dp_off = dp_diff[10:0];
  assign in_bank = (dp_off >= context_base) &
    (dp_off < context_base + `GPR_BANK_BYTES);
  assign bit_region = (data_addr >= `DUAL_PORT_RAM_BIT_BASE) &
    (data_addr < `PRIMARY_REG_BASE);
  assign reg_area_hit = |(data_tgt_now &
    (`TGT_PRIMARY | `TGT_EXTENDED));
  // Program memories belong to the code unit, the rest to data.
  assign prog_mem_hit = |(data_tgt_now &
    (`TGT_FLASH | `TGT_PROGRAM_SRAM | `TGT_EMULATED_PROGRAM_SRAM));

  // ****************************************************************
  // Fetch answer
  // ****************************************************************
  // Results hold until the next taken fetch; done pulses one cycle.
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      fetch_done <= 1'b0;
      fetch_target <= `TGT_NONE;
      fetch_phys_addr <= 24'h000000;
      fetch_trap <= 1'b0;
    end else begin
      fetch_done <= fetch_valid;
      if (fetch_valid) begin
        fetch_target <= fetch_tgt_now;
        fetch_phys_addr <= fetch_phys_now;
        fetch_trap <= fetch_trap_now;
      end
    end
  end

  // ****************************************************************
  // Data answer
  // ****************************************************************
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      data_done <= 1'b0;
      data_target <= `TGT_NONE;
      data_phys_addr <= 24'h000000;
      data_byte_hi <= 1'b0;
      data_segment <= 8'h00;
      data_page <= 2'h0;
    end else begin
      data_done <= data_taken;
      if (data_taken) begin
        data_target <= data_tgt_now;
        data_phys_addr <= {data_phys_now[23:1],
          data_phys_now[0] & ~data_word};
        data_byte_hi <= ~data_word & data_addr[0];
        data_segment <= data_addr[23:16];
        data_page <= data_addr[15:14];
      end
    end
  end

  // ****************************************************************
  // Data attributes
  // ****************************************************************
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      data_trap <= 1'b0;
      data_write_blocked <= 1'b0;
      data_bit_ok <= 1'b0;
      data_strict_order <= 1'b0;
      code_unit_sel <= 1'b0;
    end else begin
      if (data_taken) begin
        data_trap <= data_trap_now | flash_rd_block;
        data_write_blocked <= data_write &
          (program_sram_protected | flash_wp_hit);
        data_bit_ok <= reg_area_hit |
          (data_is_dual_port_ram & (bit_region | in_bank));
        data_strict_order <= data_dec[25];
        code_unit_sel <= prog_mem_hit;
      end
    end
  end

  // ****************************************************************
  // Flash routing
  // ****************************************************************
  // Sector fields follow the data address even on fetch-only cycles.
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      flash_module_sel <= 3'h0;
      flash_sector <= 6'h00;
      flash_cluster <= 3'h0;
      flash_block <= 11'h000;
      flash_line <= 14'h0000;
    end else begin
      if (|module_busy_next) begin
        flash_module_sel <= module_busy_next;
        flash_sector <= data_addr[17:12];
        flash_cluster <= data_cluster;
        flash_block <= data_addr[17:7];
        flash_line <= data_addr[17:4];
      end
    end
  end

endmodule
`default_nettype wire

//--- hdl/memory_space_decoder_defs.vh
// Address map constants for the linear memory space decoder.
`ifndef MEMORY_SPACE_DECODER_DEFS_VH
`define MEMORY_SPACE_DECODER_DEFS_VH

// ****************************************************************
// Address map (24-bit byte addresses)
// ****************************************************************
`define ADDR_W 24
`define SEG_W 8
`define PAGE_W 2
`define FLASH_INT_BASE 24'hffff00
`define TRAP_HI_BASE 24'hf00000
`define EMULATED_PROGRAM_SRAM_MIRROR_BASE 24'he90000
`define EMULATED_PROGRAM_SRAM_BASE 24'he80000
`define PROGRAM_SRAM_MIRROR_BASE 24'he10000
`define PROGRAM_SRAM_BASE 24'he00000
`define PROG_RSV_BASE 24'hcc0000
`define FLASH2_BASE 24'hc80000
`define FLASH1_BASE 24'hc40000
`define FLASH0_BASE 24'hc00000
`define EXT_MEM_HI_BASE 24'h400000
`define EXT_IO_BASE 24'h205800
`define SERIAL_REG_BASE 24'h204000
`define CAN_REG_BASE 24'h200000
`define EXT_MEM_MID_BASE 24'h010000
`define PRIMARY_REG_BASE 24'h00fe00
`define DUAL_PORT_RAM_BASE 24'h00f600
`define DUAL_PORT_RAM_RSV_BASE 24'h00f200
`define EXTENDED_REG_BASE 24'h00f000
`define EXTRA_REG_BASE 24'h00e000
`define DATA_SRAM_BASE 24'h00a000
`define DATA_SRAM_RSV_BASE 24'h008000
`define DUAL_PORT_RAM_BIT_BASE 24'h00fd00
`define FLASH_PARAM_BASE 24'h00f000
`define REG_AREA_BYTES 24'h000200
`define FLASH_MOD_W 18
`define FLASH_SECTOR_W 12
`define FLASH_PAGE_W 7
`define FLASH_LINE_W 4
`define FLASH_CLUSTER_W 3
`define PROGRAM_SRAM_OFF_W 16
`define DUAL_PORT_RAM_OFF_W 11
`define GPR_BANK_BYTES 11'h020
`define PROGRAM_SRAM_PROT_RESET 16'h0000

// ****************************************************************
// Target codes (one-hot)
// ****************************************************************
`define TGT_W 12
`define TGT_NONE 12'h000
`define TGT_EXT 12'h001
`define TGT_EXT_IO 12'h002
`define TGT_BUS_UNIT 12'h004
`define TGT_FLASH 12'h008
`define TGT_PROGRAM_SRAM 12'h010
`define TGT_EMULATED_PROGRAM_SRAM 12'h020
`define TGT_FLASH_IF 12'h040
`define TGT_PRIMARY 12'h080
`define TGT_EXTENDED 12'h100
`define TGT_EXTRA 12'h200
`define TGT_DUAL_PORT_RAM 12'h400
`define TGT_DATA_SRAM 12'h800

`endif

//--- verif/memory_space_decoder_chk.sv
// Port assertions for the memory space decoder.
`timescale 1ns/100ps
`default_nettype none
module memory_space_decoder_chk (
  input wire sys_clk,
  input wire reset,
  input wire fetch_valid,
  input wire [23:0] fetch_addr,
  input wire fetch_done,
  input wire fetch_trap,
  input wire data_valid,
  input wire data_write,
  input wire data_word,
  input wire [23:0] data_addr,
  input wire data_ready,
  input wire data_done,
  input wire [23:0] data_phys_addr,
  input wire data_trap,
  input wire data_write_blocked,
  input wire data_strict_order,
  input wire [7:0] data_segment,
  input wire [1:0] data_page,
  input wire [15:0] program_sram_protect_size
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire tk = data_valid && data_ready;
  AST_FETCH_DONE: assert property (fetch_valid |=> fetch_done)
    else $error("fetch not answered");
  AST_DATA_DONE: assert property (tk |=> data_done)
    else $error("data not answered");
  AST_SEG_PAGE: assert property (tk |=> {data_segment, data_page} ==
    $past(data_addr[23:14])) else $error("segment or page wrong");
  AST_STRICT_IO: assert property (tk && data_addr >= 24'h205800 &&
    data_addr < 24'h400000 |=> data_strict_order) else $error("io order");
  AST_PARAM_TRAP: assert property (fetch_valid &&
    fetch_addr[23:12] == 12'hc0f |=> fetch_trap) else $error("no trap");
  AST_WORD_EVEN: assert property (tk && data_word |=>
    !data_phys_addr[0]) else $error("word address odd");
  AST_PROGRAM_SRAM_WP: assert property (tk && data_write &&
    data_addr[23:16] == 8'he0 && data_addr[15:0] < program_sram_protect_size
    |=> data_write_blocked) else $error("protected write passed");
  AST_HI_TRAP: assert property (tk && data_addr[23:20] == 4'hf &&
    data_addr[23:8] != 16'hffff |=> data_trap) else $error("no trap");
  C_DUAL_PORT_RAM: cover property (tk && data_addr[23:8] == 16'h00fd);
  C_REFUSE: cover property (data_valid && !data_ready);
  C_BOTH: cover property (tk && fetch_valid);
endmodule
bind memory_space_decoder memory_space_decoder_chk i_chk (
  .sys_clk(sys_clk), .reset(reset), .fetch_valid(fetch_valid),
  .fetch_addr(fetch_addr), .fetch_done(fetch_done),
  .fetch_trap(fetch_trap), .data_valid(data_valid),
  .data_write(data_write), .data_word(data_word), .data_addr(data_addr),
  .data_ready(data_ready), .data_done(data_done),
  .data_phys_addr(data_phys_addr), .data_trap(data_trap),
  .data_write_blocked(data_write_blocked),
  .data_strict_order(data_strict_order), .data_segment(data_segment),
  .data_page(data_page), .program_sram_protect_size(program_sram_protect_size)
);
`default_nettype wire

//--- verif/fetch_unit_model.sv
// Code fetch unit of the processor core, issuing one fetch per start.
`timescale 1ns/100ps
`default_nettype none
module fetch_unit_model (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [23:0] start_addr,
  input wire logic fetch_ready,
  output logic fetch_valid,
  output logic [23:0] fetch_addr
);
  // An idle address bus shows the inverse of its last value.
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      fetch_valid <= 1'b0;
      fetch_addr <= 24'h000000;
    end else if (!fetch_valid || fetch_ready) begin
      fetch_valid <= start;
      fetch_addr <= start ? start_addr : ~fetch_addr;
    end
  end
endmodule
`default_nettype wire

//--- verif/memory_space_decoder_tb.sv
// Self-checking bench for the memory space decoder.
`timescale 1ns/100ps
`default_nettype none
`include "memory_space_decoder_defs.vh"
module memory_space_decoder_tb;
  logic sys_clk = 0, reset = 1, start = 0, data_valid = 0, data_write = 0;
  logic data_word = 0, flash_read_protect = 0, flash_unlocked = 0, rdy;
  logic dn, fd;
  logic [23:0] start_addr = 24'h0, data_addr = 24'h0;
  logic [15:0] program_sram_protect_size = 16'h0;
  logic [7:0] flash_wp_clusters = 8'h0;
  logic [10:0] context_base = 11'h0;
  wire fetch_valid, fetch_ready, fetch_done, fetch_trap, data_ready;
  wire data_done, data_byte_hi, data_trap, data_write_blocked, data_bit_ok;
  wire data_strict_order, code_unit_sel;
  wire [23:0] fetch_addr, fetch_phys_addr, data_phys_addr;
  wire [11:0] fetch_target, data_target;
  wire [7:0] data_segment;
  wire [1:0] data_page;
  wire [2:0] flash_module_sel, flash_cluster;
  wire [5:0] flash_sector;
  wire [10:0] flash_block;
  wire [13:0] flash_line;
  int errors = 0, cmp_count = 0, cycles = 0;
  memory_space_decoder i_memory_space_decoder (
    .sys_clk(sys_clk), .reset(reset), .fetch_valid(fetch_valid),
    .fetch_addr(fetch_addr), .fetch_ready(fetch_ready),
    .fetch_done(fetch_done), .fetch_target(fetch_target),
    .fetch_phys_addr(fetch_phys_addr), .fetch_trap(fetch_trap),
    .data_valid(data_valid), .data_write(data_write),
    .data_word(data_word), .data_addr(data_addr),
    .data_ready(data_ready), .data_done(data_done),
    .data_target(data_target), .data_phys_addr(data_phys_addr),
    .data_byte_hi(data_byte_hi), .data_trap(data_trap),
    .data_write_blocked(data_write_blocked), .data_bit_ok(data_bit_ok),
    .data_strict_order(data_strict_order), .code_unit_sel(code_unit_sel),
    .data_segment(data_segment), .data_page(data_page),
    .flash_module_sel(flash_module_sel), .flash_sector(flash_sector),
    .flash_cluster(flash_cluster), .flash_block(flash_block),
    .flash_line(flash_line), .program_sram_protect_size(program_sram_protect_size),
    .flash_wp_clusters(flash_wp_clusters),
    .flash_read_protect(flash_read_protect),
    .flash_unlocked(flash_unlocked), .context_base(context_base)
  );
  fetch_unit_model i_fetch_unit_model (
    .sys_clk(sys_clk), .reset(reset), .start(start),
    .start_addr(start_addr), .fetch_ready(fetch_ready),
    .fetch_valid(fetch_valid), .fetch_addr(fetch_addr)
  );
  always #2.5 sys_clk = ~sys_clk;
  task chk(input string nm, input logic [23:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s exp %h got %h", nm, exp, got);
    end
  endtask
  task xfer(input logic fv, input logic [23:0] fa, input logic dv, w, wd,
            input logic [23:0] da);
    @(posedge sys_clk) #1 {start, start_addr} = {fv, fa};
    @(posedge sys_clk) #1 start = 0;
    {data_valid, data_write, data_word, data_addr} = {dv, w, wd, da};
    #1 rdy = data_ready;
    @(posedge sys_clk) #1 data_valid = 0;
    data_addr = ~data_addr;
    dn = data_done;
    fd = fetch_done;
    @(posedge sys_clk) #1;
  endtask
  task dreq(input logic w, wd, input logic [23:0] a);
    xfer(1'b0, 24'h0, 1'b1, w, wd, a);
  endtask
  task tgt(input logic [23:0] a, input logic [11:0] t);
    dreq(1'b0, 1'b0, a);
    chk("data_target", {12'h0, t}, data_target);
  endtask
  task t_map;
    tgt(24'h00fe00, `TGT_PRIMARY);
    tgt(24'h00f1fe, `TGT_EXTENDED);
    tgt(24'h00dfff, `TGT_DATA_SRAM);
    tgt(24'hbfffff, `TGT_EXT);
    tgt(24'h2057ff, `TGT_BUS_UNIT);
    tgt(24'h205800, `TGT_EXT_IO);
    chk("data_strict_order", 24'h1, data_strict_order);
    tgt(24'hcbffff, `TGT_FLASH);
    chk("code_unit_sel", 24'h1, code_unit_sel);
    tgt(24'hffff00, `TGT_FLASH_IF);
    dreq(1'b1, 1'b1, 24'h00fffe);
    chk("data_target", `TGT_PRIMARY, data_target);
    $display("t_map end");
  endtask
  task t_seg;
    tgt(24'h00fd10, `TGT_DUAL_PORT_RAM);
    chk("data_bit_ok", 24'h1, data_bit_ok);
    dreq(1'b0, 1'b0, 24'h7fc001);
    chk("seg_page", 24'h1ff, {data_segment, data_page});
    chk("data_byte_hi", 24'h1, data_byte_hi);
    dreq(1'b1, 1'b1, 24'h7fc002);
    chk("data_phys_addr", 24'h7fc002, data_phys_addr);
    context_base = 11'h100;
    dreq(1'b0, 1'b0, 24'h00f71e);
    chk("data_bit_ok", 24'h1, data_bit_ok);
    dreq(1'b0, 1'b0, 24'h00f720);
    chk("data_bit_ok", 24'h0, data_bit_ok);
    $display("t_seg end");
  endtask
  task t_trap;
    dreq(1'b0, 1'b0, 24'he9abcd);
    chk("data_phys_addr", 24'he8abcd, data_phys_addr);
    dreq(1'b0, 1'b0, 24'he7abcd);
    chk("data_phys_addr", 24'he0abcd, data_phys_addr);
    tgt(24'hf00000, `TGT_NONE);
    chk("data_trap", 24'h1, data_trap);
    $display("t_trap end");
  endtask
  task t_prot;
    program_sram_protect_size = 16'h0100;
    dreq(1'b1, 1'b1, 24'he000fe);
    chk("data_write_blocked", 24'h1, data_write_blocked);
    dreq(1'b1, 1'b1, 24'he00100);
    chk("data_write_blocked", 24'h0, data_write_blocked);
    flash_wp_clusters = 8'h02;
    dreq(1'b1, 1'b0, 24'hc48000);
    chk("data_write_blocked", 24'h1, data_write_blocked);
    chk("flash_cluster", 24'h1, flash_cluster);
    flash_read_protect = 1;
    dreq(1'b0, 1'b0, 24'hc45080);
    chk("data_trap", 24'h1, data_trap);
    flash_unlocked = 1;
    dreq(1'b0, 1'b0, 24'hc45080);
    chk("data_trap", 24'h0, data_trap);
    chk("flash_block", 24'h0000a1, flash_block);
    chk("flash_line", 24'h000508, flash_line);
    chk("flash_sector", 24'h000005, flash_sector);
    $display("t_prot end");
  endtask
  task t_fetch;
    xfer(1'b1, 24'hc0f000, 1'b0, 1'b0, 1'b0, 24'h0);
    chk("fetch_trap", 24'h1, fetch_trap);
    xfer(1'b1, 24'he00000, 1'b1, 1'b1, 1'b1, 24'h00a000);
    chk("fetch_target", `TGT_PROGRAM_SRAM, fetch_target);
    chk("fetch_phys_addr", 24'he00000, fetch_phys_addr);
    chk("fetch_done", 24'h1, fd);
    chk("fetch_ready", 24'h1, fetch_ready);
    chk("data_done", 24'h1, dn);
    xfer(1'b1, 24'hc00000, 1'b1, 1'b0, 1'b0, 24'hc40010);
    chk("data_ready", 24'h1, rdy);
    chk("flash_module_sel", 24'h3, flash_module_sel);
    xfer(1'b1, 24'hc40000, 1'b1, 1'b0, 1'b0, 24'hc40010);
    chk("data_ready", 24'h0, rdy);
    chk("data_done", 24'h0, dn);
    chk("flash_module_sel", 24'h2, flash_module_sel);
    $display("t_fetch end");
  endtask
  task finish_test;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      finish_test;
    end
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    #1 reset = 0;
    t_map;
    t_seg;
    t_trap;
    t_prot;
    t_fetch;
    finish_test;
  end
endmodule
`default_nettype wire
